// ==== core_model.sv ====
// Core and timer-zero model facing the interrupt logic
`timescale 1ns/1ps
module core_model #(
	parameter int SVC = 40
) (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic tmr_run,
	input  wire logic IRQ_TAKE,
	output logic      TIMER_ZERO_ROLL,
	output logic      RETURN_FROM_IRQ
);
	logic [7:0] count_reg;
	int         svc_reg;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count_reg <= 8'h00;
			svc_reg <= 0;
			TIMER_ZERO_ROLL <= 1'b0;
			RETURN_FROM_IRQ <= 1'b0;
		end else begin
			if (tmr_run)
				count_reg <= count_reg + 8'h01;
			TIMER_ZERO_ROLL <= tmr_run && count_reg == 8'hFF;
			// Service routine runs a fixed time; the bench clears flags meanwhile
			if (IRQ_TAKE)
				svc_reg <= SVC;
			else if (svc_reg > 0)
				svc_reg <= svc_reg - 1;
			RETURN_FROM_IRQ <= svc_reg == 1;
		end
	end
endmodule : core_model

// ==== irq_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the interrupt logic
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH
`define OFS_CONTROL     12'h000
`define OFS_FLAG_A      12'h004
`define OFS_FLAG_B      12'h008
`define OFS_ENABLE_A    12'h00C
`define OFS_ENABLE_B    12'h010
`define OFS_OPTION      12'h014
`define OFS_CORE        12'h018
`define OFS_STATUS      12'h01C
`define BIT_GIE         7
`define BIT_PERIPHERAL_IRQ_ENABLE        6
`define BIT_TZ_EN       5
`define BIT_EXT_EN      4
`define BIT_PC_EN       3
`define BIT_TZ_FLAG     2
`define BIT_EXT_FLAG    1
`define BIT_PC_FLAG     0
`define BIT_EDGE_SEL    6
`define RST_CONTROL     8'h00
`define RST_OPTION      8'hFF
`define RST_PERIPH      8'h00
`define IRQ_VECTOR      13'h0004
`define CLK_HZ          100000000
`define INSTR_HZ        25000000
`define INSTR_DIV       (`CLK_HZ / `INSTR_HZ)
`define LAT_CYC         3
`endif

// ==== irq_logic.sv ====
// Interrupt controller of an 8-bit microcontroller with an AXI4-Lite register slave
`timescale 1ns/1ps
`include "irq_cfg.svh"
module irq_logic
	import irq_pkg::*;
(
	input  wire logic        CLK_SYS,
	input  wire logic        RSTN,
	input  wire logic        EXT_IRQ_PIN,
	input  wire logic [3:0]  PORT_B_HIGH,
	input  wire logic        TIMER_ZERO_ROLL,
	input  wire logic [7:0]  PERIPH_EVT_A,
	input  wire logic [7:0]  PERIPH_EVT_B,
	input  wire logic        RETURN_FROM_IRQ,
	input  wire logic        SLEEP_ENTER,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [11:0] AWADDR,
	input  wire logic        WVALID,
	output logic             WREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	output logic             BVALID,
	input  wire logic        BREADY,
	output logic [1:0]       BRESP,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	input  wire logic [11:0] ARADDR,
	output logic             RVALID,
	input  wire logic        RREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             IRQ_TAKE,
	output logic [12:0]      IRQ_VECTOR,
	output logic             WAKE,
	output logic             ASLEEP
);
	logic [7:0]  control_reg, flag_a_reg, flag_b_reg, en_a_reg, en_b_reg, option_reg;
	logic [7:0]  control_next, flag_a_next, flag_b_next;
	logic        pin_reg;
	logic        primed_reg;
	logic [3:0]  port_b_pins_reg;
	logic [1:0]  div_reg;
	logic [1:0]  lat_reg;
	core_state_t state_reg;
	core_req_t   req_reg;
	logic        aw_got, w_got;
	logic [11:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic        w_lane0;
	logic        instr_tick;
	assign instr_tick = (div_reg == 2'(`INSTR_DIV - 1));

	// Edge of the pin in the polarity chosen by software
	wire rise_edge    = EXT_IRQ_PIN & ~pin_reg;
	wire fall_edge    = ~EXT_IRQ_PIN & pin_reg;
	// History registers hold reset values in the first cycle, so no edge is trusted then
	wire ext_event    = primed_reg & (option_reg[`BIT_EDGE_SEL] ? rise_edge : fall_edge);
	wire pc_event     = primed_reg & |(PORT_B_HIGH ^ port_b_pins_reg);

	// Write decode; a write lands when both address and data are held
	wire wr_fire      = aw_got & w_got & ~BVALID;
	wire wr_ctl       = wr_fire & w_lane0 & (aw_addr_reg == `OFS_CONTROL);
	wire wr_fa        = wr_fire & w_lane0 & (aw_addr_reg == `OFS_FLAG_A);
	wire wr_fb        = wr_fire & w_lane0 & (aw_addr_reg == `OFS_FLAG_B);
	wire wr_ea        = wr_fire & w_lane0 & (aw_addr_reg == `OFS_ENABLE_A);
	wire wr_eb        = wr_fire & w_lane0 & (aw_addr_reg == `OFS_ENABLE_B);
	wire wr_opt       = wr_fire & w_lane0 & (aw_addr_reg == `OFS_OPTION);
	wire wr_mapped    = (aw_addr_reg[11:5] == 7'h00) & (aw_addr_reg[4:2] != 3'h7) & (aw_addr_reg[4:2] != 3'h6);
	assign w_lane0    = WSTRB[0];

	// Per-source pending terms; peripheral group gated by its own enable for takes, ungated in raw_wake
	wire periph_pend  = |(flag_a_reg & en_a_reg) | |(flag_b_reg & en_b_reg);
	wire ctl_pend     = (control_reg[`BIT_EXT_FLAG] & control_reg[`BIT_EXT_EN])
	                  | (control_reg[`BIT_TZ_FLAG] & control_reg[`BIT_TZ_EN])
	                  | (control_reg[`BIT_PC_FLAG] & control_reg[`BIT_PC_EN]);
	wire any_pend     = ctl_pend | (periph_pend & control_reg[`BIT_PERIPHERAL_IRQ_ENABLE]);
	wire raw_wake     = ctl_pend | periph_pend;
	wire take_now     = (state_reg == ST_VEC) & instr_tick & control_reg[`BIT_GIE];

	// Flag update: software write first, hardware events then override
	always_comb begin
		control_next = control_reg;
		flag_a_next  = flag_a_reg;
		flag_b_next  = flag_b_reg;
		if (wr_ctl)
			control_next = w_data_reg[7:0];
		if (wr_fa)
			flag_a_next = w_data_reg[7:0];
		if (wr_fb)
			flag_b_next = w_data_reg[7:0];
		if (RETURN_FROM_IRQ)
			control_next[`BIT_GIE] = 1'b1;
		if (take_now)
			control_next[`BIT_GIE] = 1'b0;
		if (ext_event)
			control_next[`BIT_EXT_FLAG] = 1'b1;
		if (TIMER_ZERO_ROLL)
			control_next[`BIT_TZ_FLAG] = 1'b1;
		if (pc_event)
			control_next[`BIT_PC_FLAG] = 1'b1;
		flag_a_next = flag_a_next | PERIPH_EVT_A;
		flag_b_next = flag_b_next | PERIPH_EVT_B;
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			control_reg <= `RST_CONTROL;
			flag_a_reg  <= `RST_PERIPH;
			flag_b_reg  <= `RST_PERIPH;
			en_a_reg    <= `RST_PERIPH;
			en_b_reg    <= `RST_PERIPH;
			option_reg  <= `RST_OPTION;
			pin_reg     <= 1'b0;
			port_b_pins_reg   <= 4'h0;
			div_reg     <= 2'h0;
			primed_reg  <= 1'b0;
		end else begin
			control_reg <= control_next;
			flag_a_reg  <= flag_a_next;
			flag_b_reg  <= flag_b_next;
			pin_reg     <= EXT_IRQ_PIN;
			port_b_pins_reg   <= PORT_B_HIGH;
			div_reg     <= instr_tick ? 2'h0 : div_reg + 2'h1;
			primed_reg  <= 1'b1;
			if (wr_ea)
				en_a_reg <= w_data_reg[7:0];
			if (wr_eb)
				en_b_reg <= w_data_reg[7:0];
			if (wr_opt)
				option_reg <= w_data_reg[7:0];
		end
	end

	// Core sequencer: pending seen, fixed wait in instruction cycles, then vector
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			state_reg <= ST_RUN;
			lat_reg   <= 2'h0;
			req_reg   <= '0;
		end else begin
			req_reg.take   <= take_now;
			req_reg.vector <= `IRQ_VECTOR;
			req_reg.wake   <= 1'b0;
			case (state_reg)
				ST_RUN: begin
					if (SLEEP_ENTER && !(raw_wake && !control_reg[`BIT_GIE]))
						state_reg <= ST_SLEEP;
					else if (any_pend && control_reg[`BIT_GIE] && instr_tick) begin
						state_reg <= ST_SYNC;
						lat_reg   <= 2'h0;
					end
				end
				ST_SYNC: begin
					if (!control_reg[`BIT_GIE] || !any_pend)
						state_reg <= ST_RUN;
					else if (instr_tick) begin
						lat_reg <= lat_reg + 2'h1;
						if (lat_reg == 2'(`LAT_CYC - 2))
							state_reg <= ST_VEC;
					end
				end
				ST_VEC: begin
					if (instr_tick)
						state_reg <= ST_RUN;
				end
				ST_SLEEP: begin
					if (raw_wake) begin
						req_reg.wake <= 1'b1;
						state_reg    <= (control_reg[`BIT_GIE] && any_pend) ? ST_SYNC : ST_RUN;
						lat_reg      <= 2'h0;
					end
				end
				default: state_reg <= ST_RUN;
			endcase
		end
	end

	// AXI4-Lite slave, one write and one read at a time
	wire [11:0] rd_addr = ARADDR;
	wire        rd_map  = (rd_addr[11:5] == 7'h00);
	wire [7:0]  rd_byte = (rd_addr == `OFS_CONTROL)  ? control_reg :
	                      (rd_addr == `OFS_FLAG_A)   ? flag_a_reg :
	                      (rd_addr == `OFS_FLAG_B)   ? flag_b_reg :
	                      (rd_addr == `OFS_ENABLE_A) ? en_a_reg :
	                      (rd_addr == `OFS_ENABLE_B) ? en_b_reg :
	                      (rd_addr == `OFS_OPTION)   ? option_reg :
	                      (rd_addr == `OFS_CORE)     ? {6'h00, state_reg} : 8'h00;
	wire        rd_ok   = rd_map & (rd_addr[1:0] == 2'h0) & (rd_addr[4:2] != 3'h7);

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			aw_got      <= 1'b0;
			w_got       <= 1'b0;
			aw_addr_reg <= 12'h000;
			w_data_reg  <= 32'h0000_0000;
			AWREADY     <= 1'b0;
			WREADY      <= 1'b0;
			BVALID      <= 1'b0;
			BRESP       <= 2'h0;
		end else begin
			AWREADY <= ~aw_got & ~AWREADY & AWVALID;
			WREADY  <= ~w_got & ~WREADY & WVALID;
			if (AWVALID && AWREADY) begin
				aw_got      <= 1'b1;
				aw_addr_reg <= AWADDR;
			end
			if (WVALID && WREADY) begin
				w_got      <= 1'b1;
				w_data_reg <= WDATA;
			end
			if (wr_fire) begin
				BVALID <= 1'b1;
				BRESP  <= (wr_mapped && aw_addr_reg[1:0] == 2'h0) ? 2'h0 : 2'h2;
			end else if (BVALID && BREADY) begin
				BVALID <= 1'b0;
				aw_got <= 1'b0;
				w_got  <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b0;
			RDATA   <= 32'h0000_0000;
			RRESP   <= 2'h0;
		end else begin
			ARREADY <= ARVALID & ~ARREADY & ~RVALID;
			if (ARVALID && ARREADY) begin
				RVALID <= 1'b1;
				RDATA  <= {24'h000000, rd_byte};
				RRESP  <= rd_ok ? 2'h0 : 2'h2;
			end else if (RVALID && RREADY)
				RVALID <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			IRQ_TAKE   <= 1'b0;
			IRQ_VECTOR <= 13'h0000;
			WAKE       <= 1'b0;
			ASLEEP     <= 1'b0;
		end else begin
			IRQ_TAKE   <= req_reg.take;
			IRQ_VECTOR <= req_reg.vector;
			WAKE       <= req_reg.wake;
			ASLEEP     <= (state_reg == ST_SLEEP);
		end
	end

	a_gie_reset_clear: assert property (@(posedge CLK_SYS)
		$rose(RSTN) |-> !control_reg[`BIT_GIE])
		else $error("global enable not clear after reset");
	a_no_false_edge: assert property (@(posedge CLK_SYS)
		$rose(RSTN) |=> !control_reg[`BIT_EXT_FLAG] && !control_reg[`BIT_PC_FLAG])
		else $error("false edge flag after reset");
	a_take_clears_gie: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		take_now && !RETURN_FROM_IRQ |=> !control_reg[`BIT_GIE])
		else $error("take did not clear global enable");
	a_take_needs_gie: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		!control_reg[`BIT_GIE] |-> ##2 !IRQ_TAKE)
		else $error("take without global enable");
	a_pending_starts: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		state_reg == ST_RUN && any_pend && control_reg[`BIT_GIE] && instr_tick && !SLEEP_ENTER |=> state_reg == ST_SYNC)
		else $error("pending interrupt not started");
	a_vector_fixed: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		take_now |=> ##1 IRQ_TAKE && IRQ_VECTOR == `IRQ_VECTOR)
		else $error("wrong vector");
	a_return_sets_gie: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		RETURN_FROM_IRQ && !take_now |=> control_reg[`BIT_GIE])
		else $error("return did not set global enable");
	a_ext_flag_set: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		ext_event |=> control_reg[`BIT_EXT_FLAG])
		else $error("edge flag lost");
	a_timer_flag_set: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		TIMER_ZERO_ROLL |=> control_reg[`BIT_TZ_FLAG])
		else $error("timer flag lost");
	a_periph_flag_set: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		PERIPH_EVT_A != 8'h00 |=> (flag_a_reg & $past(PERIPH_EVT_A)) == $past(PERIPH_EVT_A))
		else $error("peripheral flag lost");
	a_latency_bound: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		state_reg == ST_RUN ##1 state_reg == ST_SYNC |-> ##[4:16] state_reg != ST_SYNC)
		else $error("latency out of range");
endmodule : irq_logic

// ==== irq_logic_bench.sv ====
// Self-checking bench for the interrupt logic
`timescale 1ns/1ps
`include "irq_cfg.svh"
module irq_logic_bench;
	logic        CLK_SYS = 1'b0, RSTN = 1'b0, EXT_IRQ_PIN = 1'b0, SLEEP_ENTER = 1'b0, tmr_run = 1'b0;
	logic [3:0]  PORT_B_HIGH = 4'h0;
	logic [7:0]  PERIPH_EVT_A = 8'h00, PERIPH_EVT_B = 8'h00;
	logic        AWVALID = 1'b0, WVALID = 1'b0, ARVALID = 1'b0;
	logic [11:0] AWADDR = 12'h000, ARADDR = 12'h000;
	logic [31:0] WDATA = 32'h0, RDATA, rd;
	logic [1:0]  BRESP, RRESP, bresp_seen, rresp_seen;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ_TAKE, WAKE, ASLEEP, TIMER_ZERO_ROLL, RETURN_FROM_IRQ;
	logic [12:0] IRQ_VECTOR, vec;
	int          miscompares = 0, samples_checked = 0, cyc = 0, takes = 0, wakes = 0, take_cyc = 0, c0;
	always #5 CLK_SYS = ~CLK_SYS;
	irq_logic irq_logic_inst (.CLK_SYS, .RSTN, .EXT_IRQ_PIN, .PORT_B_HIGH, .TIMER_ZERO_ROLL, .PERIPH_EVT_A,
		.PERIPH_EVT_B, .RETURN_FROM_IRQ, .SLEEP_ENTER, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY, .WDATA,
		.WSTRB(4'hF), .BVALID, .BREADY(1'b1), .BRESP, .ARVALID, .ARREADY, .ARADDR, .RVALID, .RREADY(1'b1),
		.RDATA, .RRESP, .IRQ_TAKE, .IRQ_VECTOR, .WAKE, .ASLEEP);
	core_model core_model_inst (.clk(CLK_SYS), .rstn(RSTN), .tmr_run, .IRQ_TAKE, .TIMER_ZERO_ROLL,
		.RETURN_FROM_IRQ);
	always @(posedge CLK_SYS) begin
		cyc++;
		if (IRQ_TAKE === 1'b1) begin
			takes++;
			take_cyc = cyc;
			vec = IRQ_VECTOR;
		end
		if (WAKE === 1'b1)
			wakes++;
	end
	task automatic tick(input int k);
		repeat (k) @(posedge CLK_SYS);
	endtask : tick
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		AWADDR <= a;
		WDATA <= {24'h000000, d};
		do begin
			@(posedge CLK_SYS);
			if (AWREADY === 1'b1)
				AWVALID <= 1'b0;
			if (WREADY === 1'b1)
				WVALID <= 1'b0;
		end while (BVALID !== 1'b1);
		bresp_seen = BRESP;
	endtask : wr
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		ARVALID <= 1'b1;
		ARADDR <= a;
		do begin
			@(posedge CLK_SYS);
			if (ARREADY === 1'b1)
				ARVALID <= 1'b0;
		end while (RVALID !== 1'b1);
		rd = RDATA;
		rresp_seen = RRESP;
		chk(rd, e);
	endtask : rd_chk
	task automatic pin(input logic v);
		EXT_IRQ_PIN <= v;
		tick(6);
	endtask : pin
	// Bounded wait for the next take or wake pulse
	task automatic wait_ev(input bit wake);
		int k;
		int n;
		k = wake ? wakes : takes;
		n = 0;
		while ((wake ? wakes : takes) == k && n < 200) begin
			tick(1);
			n++;
		end
	endtask : wait_ev
	task automatic sleep;
		SLEEP_ENTER <= 1'b1;
		tick(1);
		SLEEP_ENTER <= 1'b0;
		tick(2);
		chk(32'(ASLEEP), 32'h1);
	endtask : sleep
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude
	initial begin
		tick(16);
		RSTN <= 1'b1;
		tick(1);
		for (int i = 0; i < 7; i++) begin
			rd_chk(12'(4 * i), (i == 5) ? 32'h000000FF : 32'h0);
			chk(32'(rresp_seen), 32'h0);
		end
		rd_chk(`OFS_STATUS, 32'h0);
		chk(32'(rresp_seen), 32'h2);
		wr(`OFS_STATUS, 8'hFF);
		chk(32'(bresp_seen), 32'h2);
		$display("test reset values done");
		wr(`OFS_OPTION, 8'hFF);
		chk(32'(bresp_seen), 32'h0);
		pin(1'b1);
		rd_chk(`OFS_CONTROL, 32'h02);
		wr(`OFS_CONTROL, 8'h00);
		rd_chk(`OFS_CONTROL, 32'h00);
		wr(`OFS_OPTION, 8'hBF);
		pin(1'b0);
		rd_chk(`OFS_CONTROL, 32'h02);
		wr(`OFS_CONTROL, 8'h00);
		pin(1'b1);
		rd_chk(`OFS_CONTROL, 32'h00);
		for (int i = 0; i < 4; i++) begin
			PORT_B_HIGH <= PORT_B_HIGH ^ (4'h1 << i);
			tick(6);
			rd_chk(`OFS_CONTROL, 32'h01);
			wr(`OFS_CONTROL, 8'h00);
		end
		tmr_run <= 1'b1;
		tick(260);
		tmr_run <= 1'b0;
		rd_chk(`OFS_CONTROL, 32'h04);
		wr(`OFS_CONTROL, 8'h00);
		PERIPH_EVT_A <= 8'h81;
		PERIPH_EVT_B <= 8'h10;
		tick(1);
		PERIPH_EVT_A <= 8'h00;
		PERIPH_EVT_B <= 8'h00;
		tick(2);
		rd_chk(`OFS_FLAG_A, 32'h81);
		rd_chk(`OFS_FLAG_B, 32'h10);
		// The event is placed in the very cycle in which the clear lands
		fork
			wr(`OFS_FLAG_A, 8'h00);
			begin
				tick(2);
				PERIPH_EVT_A <= 8'h02;
				tick(1);
				PERIPH_EVT_A <= 8'h00;
			end
		join
		rd_chk(`OFS_FLAG_A, 32'h02);
		wr(`OFS_FLAG_A, 8'h00);
		wr(`OFS_FLAG_B, 8'h00);
		$display("test flags done");
		wr(`OFS_ENABLE_A, 8'h01);
		wr(`OFS_CONTROL, 8'h80);
		PERIPH_EVT_A <= 8'h01;
		tick(1);
		PERIPH_EVT_A <= 8'h00;
		tick(40);
		chk(takes, 0);
		wr(`OFS_CONTROL, 8'hC0);
		wait_ev(0);
		chk(takes, 1);
		chk(32'(vec), 32'(`IRQ_VECTOR));
		rd_chk(`OFS_CONTROL, 32'h40);
		wr(`OFS_FLAG_A, 8'h00);
		tick(60);
		rd_chk(`OFS_CONTROL, 32'hC0);
		chk(takes, 1);
		wr(`OFS_ENABLE_A, 8'h00);
		$display("test peripheral take done");
		wr(`OFS_OPTION, 8'hFF);
		pin(1'b0);
		wr(`OFS_CONTROL, 8'h90);
		EXT_IRQ_PIN <= 1'b1;
		c0 = cyc;
		wait_ev(0);
		// Edge sync adds a few clocks on top of the instruction-cycle latency
		chk(32'(take_cyc - c0 >= 3 * `INSTR_DIV && take_cyc - c0 <= 4 * `INSTR_DIV + 4), 32'h1);
		wr(`OFS_CONTROL, 8'h10);
		tick(60);
		rd_chk(`OFS_CONTROL, 32'h90);
		$display("test latency done");
		// Reset in mid-run with global enable set and the pin held high
		RSTN <= 1'b0;
		tick(2);
		RSTN <= 1'b1;
		tick(1);
		rd_chk(`OFS_CONTROL, 32'h00);
		rd_chk(`OFS_OPTION, 32'hFF);
		$display("test mid-run reset done");
		wr(`OFS_CONTROL, 8'h10);
		pin(1'b0);
		sleep();
		EXT_IRQ_PIN <= 1'b1;
		wait_ev(1);
		chk(wakes, 1);
		tick(30);
		chk(takes, 2);
		rd_chk(`OFS_CONTROL, 32'h12);
		wr(`OFS_CONTROL, 8'h90);
		pin(1'b0);
		sleep();
		EXT_IRQ_PIN <= 1'b1;
		wait_ev(0);
		chk(wakes, 2);
		chk(32'(vec), 32'(`IRQ_VECTOR));
		wr(`OFS_CONTROL, 8'h10);
		tick(60);
		$display("test sleep done");
		conclude();
	end
	initial begin
		tick(20000);
		miscompares++;
		conclude();
	end
endmodule : irq_logic_bench

// ==== irq_pkg.sv ====
// Types shared by the interrupt logic
package irq_pkg;
	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_SYNC  = 2'b01,
		ST_VEC   = 2'b11,
		ST_SLEEP = 2'b10
	} core_state_t;
	typedef struct packed {
		logic        take;
		logic [12:0] vector;
		logic        wake;
	} core_req_t;
endpackage : irq_pkg
